// file: core/slem_error_monitor.v
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`include "slem_consts.vh"

// Contract
// - Table-miss count at limit drives sync request only when its select bit is set.
// - Bad control character count at limit drives sync request only when selected.
// - Disparity count at limit does not drive sync request when deselected.
// - Mismatch flag reads one when lane 0 config differs from transmitter settings.
// - Writing one to mismatch bit clears pending mismatch interrupt.
// - Mismatch interrupt only while its enable is set; enable resets to one.
// - Each lane counts three error types, compared to 8-bit limit resetting to FF.
// - Limit hits raise interrupt, sync request or both per mask settings.
// - Four-bit lane enable, bit x enables lane x, all on after reset.
// - With ramp check off, alignment data of any content is accepted.
// - With ramp check on, alignment data must ramp from 00-01-02 or startup fails.
// - Disparity count at limit drives sync request when its select bit is set.
// - Any unmasked error condition drives active-low interrupt request low.
module slem_error_monitor (
	input wire REF_CLK_I,
	input wire RST_I,
	input wire [`SLEM_ADDR_W-1:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [7:0] RDATA_O,
	input wire [`SLEM_NLANE-1:0] DISP_ERR_I,
	input wire [`SLEM_NLANE-1:0] TABLE_MISS_I,
	input wire [`SLEM_NLANE-1:0] BAD_CTRL_I,
	input wire [7:0] LANE0_CFG_I,
	input wire ALIGN_START_I,
	input wire ALIGN_VALID_I,
	input wire [7:0] ALIGN_DATA_I,
	output wire [`SLEM_NLANE-1:0] LANE_ON_O,
	output wire ALIGN_OK_O,
	output wire SYNC_REQUEST_OUT_N_O,
	output wire IRQ_N_O
);
	reg [7:0] sync_sel_q;
	reg [7:0] limit_q;
	reg [3:0] lane_on_bits_q;
	reg ramp_verify_en_q;
	reg [`SLEM_NSTAT-1:0] stat_q;
	reg [`SLEM_NSTAT-1:0] stat_d;
	reg [`SLEM_NSTAT-1:0] irq_en_q;
	reg [7:0] cfg_exp_q;
	reg [7:0] rdata_d;
	wire [`SLEM_NLANE-1:0] hit_disp;
	wire [`SLEM_NLANE-1:0] hit_nit;
	wire [`SLEM_NLANE-1:0] hit_ucc;
	wire any_disp;
	wire any_nit;
	wire any_ucc;
	wire config_mismatch_flag;
	wire ramp_fail;
	wire wr_clr;
	wire [`SLEM_NSTAT-1:0] ev;

	genvar g;
	generate
		for (g = 0; g < `SLEM_NLANE; g = g + 1) begin : g_lane
			// One counter per lane and error type
			slem_lane_counter u_disp (
				.clk_i(REF_CLK_I),
				.rst_i(RST_I),
				.en_i(lane_on_bits_q[g]),
				.err_i(DISP_ERR_I[g]),
				.limit_i(limit_q),
				.hit_o(hit_disp[g])
			);
			slem_lane_counter u_nit (
				.clk_i(REF_CLK_I),
				.rst_i(RST_I),
				.en_i(lane_on_bits_q[g]),
				.err_i(TABLE_MISS_I[g]),
				.limit_i(limit_q),
				.hit_o(hit_nit[g])
			);
			slem_lane_counter u_ucc (
				.clk_i(REF_CLK_I),
				.rst_i(RST_I),
				.en_i(lane_on_bits_q[g]),
				.err_i(BAD_CTRL_I[g]),
				.limit_i(limit_q),
				.hit_o(hit_ucc[g])
			);
		end
	endgenerate

	slem_ramp_check u_ramp (
		.clk_i(REF_CLK_I),
		.rst_i(RST_I),
		.en_i(ramp_verify_en_q),
		.start_i(ALIGN_START_I),
		.valid_i(ALIGN_VALID_I),
		.data_i(ALIGN_DATA_I),
		.fail_o(ramp_fail)
	);

	assign any_disp = |hit_disp;
	assign any_nit = |hit_nit;
	assign any_ucc = |hit_ucc;
	assign LANE_ON_O = lane_on_bits_q;
	// Disabled check never fails, any content passes
	assign ALIGN_OK_O = ~ramp_fail;

	// Compared against transmitter settings latched by software
	assign config_mismatch_flag = (LANE0_CFG_I != cfg_exp_q);

	// Sync request: only selected causes count
	assign SYNC_REQUEST_OUT_N_O = ~((any_disp & sync_sel_q[`SLEM_B_SYNC_DISP])
		| (any_nit & sync_sel_q[`SLEM_B_SYNC_NIT])
		| (any_ucc & sync_sel_q[`SLEM_B_SYNC_UCC]));

	assign ev[`SLEM_S_DISP] = any_disp;
	assign ev[`SLEM_S_NIT] = any_nit;
	assign ev[`SLEM_S_UCC] = any_ucc;
	assign ev[`SLEM_S_CMM] = config_mismatch_flag & sync_sel_q[`SLEM_B_CMM_EN];
	assign ev[`SLEM_S_RAMP] = ramp_fail;

	assign wr_clr = WR_I && (ADDR_I == `SLEM_A_IRQ_CLR);
	assign IRQ_N_O = ~(|(stat_q & irq_en_q));

	always @* begin
		stat_d = stat_q;
		if (wr_clr)
			stat_d = stat_q & ~WDATA_I[`SLEM_NSTAT-1:0];
		if (WR_I && (ADDR_I == `SLEM_A_SYNC_SEL) && WDATA_I[`SLEM_B_CMM])
			stat_d[`SLEM_S_CMM] = 1'b0;
		// Set wins over a same-cycle clear
		stat_d = stat_d | ev;
	end

	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			sync_sel_q <= `SLEM_RST_SYNC_SEL;
			limit_q <= `SLEM_RST_THRESH;
			lane_on_bits_q <= `SLEM_RST_LANE_EN;
			ramp_verify_en_q <= `SLEM_RST_RAMP;
			irq_en_q <= `SLEM_RST_IRQ_EN;
			cfg_exp_q <= `SLEM_RST_CFG_EXP;
			stat_q <= {`SLEM_NSTAT{1'b0}};
		end else begin
			stat_q <= stat_d;
			if (WR_I) begin
				case (ADDR_I)
				`SLEM_A_SYNC_SEL: begin
					// Mismatch bit is a clear strobe, not stored
					sync_sel_q <= {WDATA_I[7:5], 1'b0, WDATA_I[3], 3'h0};
				end
				`SLEM_A_THRESH: limit_q <= WDATA_I;
				// Lanes must be set before code group sync starts
				`SLEM_A_LANE_EN: lane_on_bits_q <= WDATA_I[3:0];
				`SLEM_A_RAMP: ramp_verify_en_q <= WDATA_I[`SLEM_B_RAMP_EN];
				`SLEM_A_IRQ_EN: irq_en_q <= WDATA_I[`SLEM_NSTAT-1:0];
				`SLEM_A_CFG_EXP: cfg_exp_q <= WDATA_I;
				default: ;
				endcase
			end
		end
	end

	always @* begin
		rdata_d = `SLEM_ZERO8;
		case (ADDR_I)
		`SLEM_A_SYNC_SEL: begin
			rdata_d = sync_sel_q;
			rdata_d[`SLEM_B_CMM] = config_mismatch_flag;
		end
		`SLEM_A_THRESH: rdata_d = limit_q;
		`SLEM_A_LANE_EN: rdata_d = {4'h0, lane_on_bits_q};
		`SLEM_A_RAMP: rdata_d = {7'h00, ramp_verify_en_q};
		`SLEM_A_IRQ_STAT: rdata_d = {3'h0, stat_q};
		`SLEM_A_IRQ_EN: rdata_d = {3'h0, irq_en_q};
		`SLEM_A_LANE_ERR: rdata_d = {ramp_fail, any_ucc, any_nit, any_disp, lane_on_bits_q};
		`SLEM_A_CFG_EXP: rdata_d = cfg_exp_q;
		default: rdata_d = `SLEM_ZERO8;
		endcase
	end

	// Read data valid only the cycle after the strobe
	always @(posedge REF_CLK_I) begin
		if (RST_I)
			RDATA_O <= `SLEM_ZERO8;
		else if (RD_I)
			RDATA_O <= rdata_d;
		else
			RDATA_O <= `SLEM_ZERO8;
	end
endmodule // slem_error_monitor

// file: core/slem_lane_counter.v
`timescale 1ns/10ps
`include "slem_consts.vh"

module slem_lane_counter (
	input wire clk_i,
	input wire rst_i,
	input wire en_i,
	input wire err_i,
	input wire [`SLEM_CNT_W-1:0] limit_i,
	output reg hit_o
);
	reg [`SLEM_CNT_W-1:0] cnt_q;

	always @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			cnt_q <= `SLEM_ZERO8;
			hit_o <= 1'b0;
		end else begin
			// Saturates so the hit stays up until lane reset
			if (err_i && (cnt_q != {`SLEM_CNT_W{1'b1}}))
				cnt_q <= cnt_q + `SLEM_ONE8;
			hit_o <= (cnt_q >= limit_i);
		end
	end
endmodule // slem_lane_counter

// file: core/slem_ramp_check.v
`timescale 1ns/10ps
`include "slem_consts.vh"

module slem_ramp_check (
	input wire clk_i,
	input wire rst_i,
	input wire en_i,
	input wire start_i,
	input wire valid_i,
	input wire [7:0] data_i,
	output reg fail_o
);
	reg [2:0] idx_q;
	reg active_q;

	always @(posedge clk_i) begin
		if (rst_i || start_i) begin
			idx_q <= 3'h0;
			active_q <= start_i;
			fail_o <= 1'b0;
		end else if (active_q && valid_i) begin
			// Only the first octets must follow 00-01-02
			if (en_i && (data_i != {5'h00, idx_q}))
				fail_o <= 1'b1;
			idx_q <= idx_q + 3'h1;
			if (idx_q == `SLEM_RAMP_LEN - 3'h1)
				active_q <= 1'b0;
		end
	end
endmodule // slem_ramp_check

// file: include/slem_consts.vh
`ifndef SLEM_CONSTS_VH
`define SLEM_CONSTS_VH

// Register index map (byte-wide registers)
`define SLEM_ADDR_W 12
`define SLEM_A_SYNC_SEL 12'h047B
`define SLEM_A_THRESH 12'h047C
`define SLEM_A_LANE_EN 12'h047D
`define SLEM_A_RAMP 12'h047E
`define SLEM_A_IRQ_STAT 12'h0480
`define SLEM_A_IRQ_EN 12'h0481
`define SLEM_A_IRQ_CLR 12'h0482
`define SLEM_A_LANE_ERR 12'h0483
`define SLEM_A_CFG_EXP 12'h0484

// Field positions
`define SLEM_B_SYNC_DISP 7
`define SLEM_B_SYNC_NIT 6
`define SLEM_B_SYNC_UCC 5
`define SLEM_B_CMM 4
`define SLEM_B_CMM_EN 3
`define SLEM_B_RAMP_EN 0

// Status bit layout
`define SLEM_S_DISP 0
`define SLEM_S_NIT 1
`define SLEM_S_UCC 2
`define SLEM_S_CMM 3
`define SLEM_S_RAMP 4
`define SLEM_NSTAT 5

// Reset values
`define SLEM_RST_SYNC_SEL 8'h08
`define SLEM_RST_THRESH 8'hFF
`define SLEM_RST_LANE_EN 4'hF
`define SLEM_RST_RAMP 1'b0
`define SLEM_RST_IRQ_EN 5'h00
`define SLEM_RST_CFG_EXP 8'h00

`define SLEM_NLANE 4
`define SLEM_CNT_W 8
`define SLEM_ZERO8 8'h00
`define SLEM_ONE8 8'h01
`define SLEM_RAMP_LEN 3'h3

`endif

// file: tb/slem_error_monitor_tb.sv
`timescale 1ns/10ps
module slem_error_monitor_tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg [11:0] addr = 12'h000;
	reg [7:0] wdata = 8'h00;
	reg [7:0] cfg = 8'h00;
	wire [7:0] rdata, adata;
	wire [3:0] disp, nit, ucc, lane_on;
	wire start, valid, ok, sync_n, irq_n;
	integer n_mismatch = 0;
	integer samples_checked = 0;
	integer k, s;
	always #25 clk = ~clk;
	slem_error_monitor u_slem_error_monitor (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .DISP_ERR_I(disp),
		.TABLE_MISS_I(nit), .BAD_CTRL_I(ucc), .LANE0_CFG_I(cfg), .ALIGN_START_I(start),
		.ALIGN_VALID_I(valid), .ALIGN_DATA_I(adata), .LANE_ON_O(lane_on), .ALIGN_OK_O(ok),
		.SYNC_REQUEST_OUT_N_O(sync_n), .IRQ_N_O(irq_n));
	slem_tx_model u_slem_tx_model (.clk_i(clk), .disp_o(disp), .nit_o(nit), .ucc_o(ucc),
		.start_o(start), .valid_o(valid), .data_o(adata));
	task chk(input [7:0] got, input [7:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr_reg(input [11:0] a, input [7:0] d);
		@(posedge clk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_chk(input [11:0] a, input [7:0] e);
		@(posedge clk);
		{rd, addr} <= {1'b1, a};
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	task settle;
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask
	task do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
	endtask
	task print_verdict;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		do_reset;
		rd_chk(12'h047C, 8'hFF);
		rd_chk(12'h047D, 8'h0F);
		rd_chk(12'h047E, 8'h00);
		rd_chk(12'h047B, 8'h08);
		rd_chk(12'h0000, 8'h00);
		wr_reg(12'h047D, 8'h05);
		@(negedge clk);
		chk({4'h0, lane_on}, 8'h05);
		// Limit of two on a different lane per error kind, select on and off
		for (s = 0; s < 2; s = s + 1) begin
			for (k = 0; k < 3; k = k + 1) begin
				do_reset;
				wr_reg(12'h047C, 8'h02);
				wr_reg(12'h047B, ((8'h80 >> k) & {8{s[0]}}) | 8'h08);
				wr_reg(12'h0481, 8'h01 << k);
				u_slem_tx_model.err(k, k + 1, 2);
				settle;
				chk({7'h0, sync_n}, {7'h0, ~s[0]});
				chk({7'h0, irq_n}, 8'h00);
				rd_chk(12'h0480, 8'h01 << k);
			end
		end
		// Disabled lane must not count
		wr_reg(12'h047B, 8'hE8);
		wr_reg(12'h047D, 8'h0D);
		do_reset;
		wr_reg(12'h047B, 8'hE8);
		wr_reg(12'h047D, 8'h0D);
		wr_reg(12'h047C, 8'h02);
		u_slem_tx_model.err(1, 1, 4);
		settle;
		chk({7'h0, sync_n}, 8'h01);
		rd_chk(12'h0483, 8'h0D);
		cfg <= 8'h5A;
		wr_reg(12'h0481, 8'h08);
		rd_chk(12'h047B, 8'hF8);
		chk({7'h0, irq_n}, 8'h00);
		wr_reg(12'h047B, 8'h10);
		wr_reg(12'h0482, 8'h08);
		settle;
		chk({7'h0, irq_n}, 8'h01);
		wr_reg(12'h0484, 8'h5A);
		rd_chk(12'h047B, 8'h00);
		u_slem_tx_model.ilas(8'h05);
		settle;
		chk({7'h0, ok}, 8'h01);
		wr_reg(12'h047E, 8'h01);
		u_slem_tx_model.ilas(8'h00);
		settle;
		chk({7'h0, ok}, 8'h01);
		u_slem_tx_model.ilas(8'h05);
		settle;
		chk({7'h0, ok}, 8'h00);
		print_verdict;
	end
endmodule // slem_error_monitor_tb

// file: tb/slem_mon_monitor.sv
`timescale 1ns/10ps
module slem_mon (
	input wire REF_CLK_I,
	input wire RST_I,
	input wire [11:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	input wire [7:0] RDATA_O,
	input wire ALIGN_START_I,
	input wire ALIGN_VALID_I,
	input wire [7:0] ALIGN_DATA_I,
	input wire [3:0] LANE_ON_O,
	input wire ALIGN_OK_O,
	input wire SYNC_REQUEST_OUT_N_O,
	input wire IRQ_N_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	// Shadows of control bits, so gating can be checked without peeking inside
	reg [2:0] sel_q;
	reg [4:0] ien_q;
	reg ramp_q;
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			sel_q <= 3'h0;
			ien_q <= 5'h00;
			ramp_q <= 1'b0;
		end else if (WR_I) begin
			if (ADDR_I == 12'h047B) sel_q <= WDATA_I[7:5];
			if (ADDR_I == 12'h0481) ien_q <= WDATA_I[4:0];
			if (ADDR_I == 12'h047E) ramp_q <= WDATA_I[0];
		end
	end
	sequence s_bad_first;
		ALIGN_START_I && ramp_q ##1 ALIGN_VALID_I && ALIGN_DATA_I != 8'h00;
	endsequence
	a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("read data not idle");
	a_lane_write: assert property (WR_I && ADDR_I == 12'h047D |=> LANE_ON_O == $past(WDATA_I[3:0]))
		else $error("lane enable not written");
	a_lane_read: assert property (RD_I && ADDR_I == 12'h047D |=> RDATA_O == {4'h0, LANE_ON_O})
		else $error("lane enable readback wrong");
	a_sync_gated: assert property (sel_q == 3'h0 |-> SYNC_REQUEST_OUT_N_O)
		else $error("sync request without select");
	a_irq_gated: assert property (ien_q == 5'h00 |-> IRQ_N_O)
		else $error("interrupt without enable");
	a_ramp_off: assert property (!ramp_q && ALIGN_OK_O |=> ALIGN_OK_O)
		else $error("alignment failed with check off");
	a_ramp_fail: assert property (s_bad_first |-> ##[1:4] !ALIGN_OK_O)
		else $error("bad ramp not flagged");
	a_fail_hold: assert property (!ALIGN_OK_O && !ALIGN_START_I |=> !ALIGN_OK_O)
		else $error("alignment failure not held");
endmodule // slem_mon
bind slem_error_monitor slem_mon u_slem_mon (.*);

// file: tb/slem_tx_model.sv
`timescale 1ns/10ps
module slem_tx_model (
	input wire clk_i,
	output reg [3:0] disp_o,
	output reg [3:0] nit_o,
	output reg [3:0] ucc_o,
	output reg start_o,
	output reg valid_o,
	output reg [7:0] data_o
);
	initial {disp_o, nit_o, ucc_o, start_o, valid_o, data_o} = 22'h00_0000;
	// Kind 0 disparity, 1 table miss, 2 control char; one count per clock
	task err(input integer kind, input integer lane, input integer n);
		integer i;
		for (i = 0; i < n; i = i + 1) begin
			@(posedge clk_i);
			{disp_o, nit_o, ucc_o} <= 12'h001 << (lane + 4 * (2 - kind));
		end
		@(posedge clk_i);
		{disp_o, nit_o, ucc_o} <= 12'h000;
	endtask
	// Alignment octets; offset 0 gives the 00-01-02 ramp
	task ilas(input [7:0] ofs);
		integer i;
		@(posedge clk_i);
		start_o <= 1'b1;
		for (i = 0; i < 3; i = i + 1) begin
			@(posedge clk_i);
			start_o <= 1'b0;
			valid_o <= 1'b1;
			data_o <= i[7:0] + ofs;
		end
		@(posedge clk_i);
		valid_o <= 1'b0;
		data_o <= ~data_o;
	endtask
endmodule // slem_tx_model
